// ### pkg/fflu_pkg.sv
// Constants shared by the flag-timing FIFO block
package fflu_pkg;

   // ======================================================
   // Register map (byte addresses)
   localparam int unsigned   ADDR_W         = 5;
   localparam logic [4:0]    ADDR_THRESH    = 5'h00;
   localparam logic [4:0]    ADDR_STATUS    = 5'h04;
   localparam logic [4:0]    ADDR_IRQ_STAT  = 5'h08;
   localparam logic [4:0]    ADDR_IRQ_CLR   = 5'h0C;
   localparam logic [4:0]    ADDR_IRQ_EN    = 5'h10;

   // ======================================================
   // Field layout
   localparam int unsigned   FILL_W         = 12;
   localparam int unsigned   THR_HIGH_LSB   = 0;
   localparam int unsigned   THR_LOW_LSB    = 16;
   localparam int unsigned   WFILL_LSB      = 8;
   localparam int unsigned   RFILL_LSB      = 20;
   localparam int unsigned   FLAG_W         = 7;
   localparam int unsigned   IRQ_W          = 6;

   // Interrupt event bits
   localparam int unsigned   EV_OVERFLOW    = 0;
   localparam int unsigned   EV_UNDERFLOW   = 1;
   localparam int unsigned   EV_FULL        = 2;
   localparam int unsigned   EV_THR_HIGH    = 3;
   localparam int unsigned   EV_THR_LOW     = 4;
   localparam int unsigned   EV_EMPTY       = 5;

   // ======================================================
   // Reset values
   localparam logic [11:0]   THR_HIGH_RST   = 12'h300;
   localparam logic [11:0]   THR_LOW_RST    = 12'h100;
   localparam logic [5:0]    IRQ_EN_RST     = 6'h00;

   // ======================================================
   // Pipeline lags in destination ticks, ECC primitive depth and pin sync stages
   localparam int unsigned   IND_WR_LAG     = 1;
   localparam int unsigned   IND_RD_LAG     = 3;
   localparam int unsigned   IND_FILL_TAP   = 1;
   localparam int unsigned   BOTH_REG_EXTRA = 1;
   localparam int unsigned   HARD_WR_LAG    = 2;
   localparam int unsigned   ECC_PRIM_DEPTH = 512;
   localparam int unsigned   PIN_SYNC       = 2;

   // ======================================================
   // Bus answers
   localparam logic [1:0]    RESP_OKAY      = 2'h0;
   localparam logic [1:0]    RESP_SLVERR    = 2'h2;

endpackage

// ### logic/fflu_fifo_flags.sv
// Dual-variant FIFO with documented flag update timing and AXI4-Lite regs
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module fflu_fifo_flags
   import fflu_pkg::*;
#(
   parameter int unsigned WIDTH       = 16,
   parameter int unsigned DEPTH       = 1024,
   parameter int unsigned SYNC_STAGES = 2,
   parameter int unsigned OUT_REGS    = 0,
   parameter bit          HARD_MACRO  = 1'b0,
   parameter bit          ECC         = 1'b1,
   parameter int unsigned PRIM_DEPTH  = 1024
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             wrClkPin,
   input  wire logic             wrReqPin,
   input  wire logic [WIDTH-1:0] wrDataPin,
   input  wire logic             rdClkPin,
   input  wire logic             rdReqPin,
   output logic                  full,
   output logic                  nearCapacity,
   output logic                  thresholdHigh,
   output logic                  wrAcceptPulse,
   output logic                  overflow,
   output logic [FILL_W-1:0]     wrFillLevel,
   output logic                  empty,
   output logic                  nearDrained,
   output logic                  thresholdLow,
   output logic                  rdValid,
   output logic                  underflow,
   output logic [FILL_W-1:0]     rdFillLevel,
   output logic [WIDTH-1:0]      rdData,
   output logic                  irq,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready
);

   // ======================================================
   // Derived sizes
   localparam int unsigned AW    = $clog2(DEPTH);
   localparam int unsigned PW    = AW + 1;
   localparam int unsigned PDEP  = ECC ? ECC_PRIM_DEPTH : PRIM_DEPTH;
   localparam int unsigned NPRIM = DEPTH / PDEP;
   localparam int unsigned BOTH  = (OUT_REGS == 2) ? BOTH_REG_EXTRA : 0;
   localparam int unsigned WL    = HARD_MACRO ? NPRIM - HARD_WR_LAG
                                              : SYNC_STAGES + IND_WR_LAG;
   localparam int unsigned RL    = HARD_MACRO ? 2 * (NPRIM - 1)
                                   : SYNC_STAGES + IND_RD_LAG + BOTH;
   localparam int unsigned FT    = HARD_MACRO ? RL - 1
                                              : SYNC_STAGES + IND_FILL_TAP;
   localparam int unsigned SW    = WIDTH + 4;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] ONE_P   = PW'(1);

   if (DEPTH != (1 << AW) || PW > FILL_W || OUT_REGS > 2
       || SYNC_STAGES < 2 || (HARD_MACRO && NPRIM < 2)) begin : g_bad
      $error("fflu_fifo_flags: unsupported parameter set");
   end

   // ======================================================
   // Functions
   function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
      toGray = b ^ (b >> 1);
   endfunction

   function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b = '0;
      b[PW-1] = g[PW-1];
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      fromGray = b;
   endfunction

   function automatic logic [31:0] laneMask(input logic [3:0] s);
      laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // ======================================================
   // Reset release and pin synchronisers
   logic [1:0]    rstSync_q;
   logic          rstN;
   logic [SW-1:0] pinS1_q;
   logic [SW-1:0] pinS2_q;
   logic [1:0]    clkPrev_q;
   wire  [SW-1:0] pinRaw = {wrClkPin, rdClkPin, wrReqPin, rdReqPin,
                            wrDataPin};

   assign rstN = rstSync_q[1];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         pinS1_q   <= '0;
         pinS2_q   <= '0;
         clkPrev_q <= 2'h0;
      end else begin
         pinS1_q   <= pinRaw;
         pinS2_q   <= pinS1_q;
         clkPrev_q <= pinS2_q[SW-1 -: 2];
      end
   end

   wire             wrClkS  = pinS2_q[SW-1];
   wire             rdClkS  = pinS2_q[SW-2];
   wire             wrReq   = pinS2_q[SW-3];
   wire             rdReq   = pinS2_q[SW-4];
   wire [WIDTH-1:0] wrData  = pinS2_q[WIDTH-1:0];
   wire             wrTick  = wrClkS & ~clkPrev_q[1];
   wire             rdTickI = rdClkS & ~clkPrev_q[0];
   wire             rdTick  = HARD_MACRO ? wrTick : rdTickI;

   // ======================================================
   // Storage and pointers
   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [PW-1:0]    wrPtr_q;
   logic [PW-1:0]    rdPtr_q;
   logic [PW-1:0]    wPipe_q [0:WL+1];
   logic [PW-1:0]    rPipe_q [0:RL];
   logic             full_q;
   logic             nearCap_q;
   logic             thrHigh_q;
   logic             wrAccept_q;
   logic             overflow_q;
   logic [PW-1:0]    wrFill_q;
   logic             outValid_q;
   logic             nearDrained_q;
   logic             thrLow_q;
   logic             underflow_q;
   logic [PW-1:0]    rdFill_q;
   logic [WIDTH-1:0] rdData_q;
   logic [11:0]      thrHigh_r;
   logic [11:0]      thrLow_r;

   // ======================================================
   // Write side
   wire [PW-1:0] rdSeenW  = fromGray(wPipe_q[WL]);
   wire [PW-1:0] rdSeenW2 = fromGray(wPipe_q[WL+1]);
   wire          wrDo     = wrTick & wrReq & ~full_q;
   wire          wrRefuse = wrTick & wrReq & full_q;
   wire [PW-1:0] wrPtr_d  = wrPtr_q + PW'(wrDo);
   wire [PW-1:0] wrCnt_d  = wrPtr_d - rdSeenW;
   wire [PW-1:0] wrCntH   = wrPtr_q - rdSeenW2;
   wire [PW-1:0] wrCntF   = wrPtr_q - rdSeenW;

   always_ff @(posedge ref_clk) begin
      if (wrDo) begin
         mem_q[wrPtr_q[AW-1:0]] <= wrData;
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         wrPtr_q    <= '0;
         full_q     <= 1'b0;
         nearCap_q  <= 1'b0;
         thrHigh_q  <= 1'b0;
         wrAccept_q <= 1'b0;
         overflow_q <= 1'b0;
         wrFill_q   <= '0;
      end else if (wrTick) begin
         wrPtr_q    <= wrPtr_d;
         full_q     <= wrCnt_d == DEPTH_P;
         nearCap_q  <= wrCnt_d >= DEPTH_P - ONE_P;
         wrAccept_q <= wrDo;
         overflow_q <= wrRefuse;
         thrHigh_q  <= FILL_W'(wrCntH) >= thrHigh_r;
         wrFill_q   <= wrCntF;
      end
   end

   // Read pointer crossing into the write side
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i <= WL + 1; i++) begin
            wPipe_q[i] <= '0;
         end
      end else begin
         wPipe_q[0] <= toGray(rdPtr_q);
         if (wrTick) begin
            for (int i = 1; i <= WL + 1; i++) begin
               wPipe_q[i] <= wPipe_q[i-1];
            end
         end
      end
   end

   // ======================================================
   // Read side, lookahead output stage
   wire [PW-1:0] wrSeenR = fromGray(rPipe_q[RL]);
   wire [PW-1:0] wrTapL  = fromGray(rPipe_q[RL-1]);
   wire [PW-1:0] wrTapF  = fromGray(rPipe_q[FT]);
   wire          avail   = wrSeenR != rdPtr_q;
   wire          rdTake  = rdTick & rdReq & outValid_q;
   wire          rdLoad  = rdTick & avail & (~outValid_q | rdReq);
   wire          valid_d = rdLoad | (outValid_q & ~rdTake);
   wire [PW-1:0] rdPtr_d = rdPtr_q + PW'(rdLoad);
   wire [PW-1:0] total_d = wrSeenR - rdPtr_d + PW'(valid_d);
   wire [PW-1:0] totalL  = wrTapL - rdPtr_q + PW'(outValid_q);
   wire [PW-1:0] totalF  = wrTapF - rdPtr_q + PW'(outValid_q);

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         rdPtr_q       <= '0;
         outValid_q    <= 1'b0;
         nearDrained_q <= 1'b1;
         thrLow_q      <= 1'b1;
         underflow_q   <= 1'b0;
         rdFill_q      <= '0;
         rdData_q      <= '0;
      end else if (rdTick) begin
         rdPtr_q       <= rdPtr_d;
         outValid_q    <= valid_d;
         nearDrained_q <= total_d <= ONE_P;
         underflow_q   <= rdReq & ~outValid_q;
         thrLow_q      <= FILL_W'(totalL) <= thrLow_r;
         rdFill_q      <= totalF;
         if (rdLoad) begin
            rdData_q <= mem_q[rdPtr_q[AW-1:0]];
         end
      end
   end

   // Write pointer crossing into the read side
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i <= RL; i++) begin
            rPipe_q[i] <= '0;
         end
      end else begin
         rPipe_q[0] <= toGray(wrPtr_q);
         if (rdTick) begin
            for (int i = 1; i <= RL; i++) begin
               rPipe_q[i] <= rPipe_q[i-1];
            end
         end
      end
   end

   assign full          = full_q;
   assign nearCapacity  = nearCap_q;
   assign thresholdHigh = thrHigh_q;
   assign wrAcceptPulse = wrAccept_q;
   assign overflow      = overflow_q;
   assign wrFillLevel   = FILL_W'(wrFill_q);
   assign empty         = ~outValid_q;
   assign nearDrained   = nearDrained_q;
   assign thresholdLow  = thrLow_q;
   assign rdValid       = outValid_q;
   assign underflow     = underflow_q;
   assign rdFillLevel   = FILL_W'(rdFill_q);
   assign rdData        = rdData_q;

   // ======================================================
   // Interrupt events
   logic [IRQ_W-1:0] irqStat_q;
   logic [IRQ_W-1:0] irqEn_q;
   logic [3:0]       flagPrev_q;
   logic [IRQ_W-1:0] irqClr;
   logic [IRQ_W-1:0] irqEvt;

   always_comb begin
      irqEvt = '0;
      irqEvt[EV_OVERFLOW]  = wrRefuse;
      irqEvt[EV_UNDERFLOW] = rdTick & rdReq & ~outValid_q;
      irqEvt[EV_FULL]      = full_q & ~flagPrev_q[0];
      irqEvt[EV_THR_HIGH]  = thrHigh_q & ~flagPrev_q[1];
      irqEvt[EV_THR_LOW]   = thrLow_q & ~flagPrev_q[2];
      irqEvt[EV_EMPTY]     = ~outValid_q & ~flagPrev_q[3];
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         irqStat_q  <= '0;
         flagPrev_q <= 4'hF;
      end else begin
         irqStat_q  <= (irqStat_q & ~irqClr) | irqEvt;
         flagPrev_q <= {~outValid_q, thrLow_q, thrHigh_q, full_q};
      end
   end

   assign irq = |(irqStat_q & irqEn_q);

   // ======================================================
   // AXI4-Lite slave
   logic              awHave_q;
   logic              wHave_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0]       wData_q;
   logic [3:0]        wStrb_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              rvalid_q;
   logic [1:0]        rresp_q;
   logic [31:0]       rdataR_q;

   wire awFire = s_axi_awvalid & s_axi_awready;
   wire wFire  = s_axi_wvalid & s_axi_wready;
   wire arFire = s_axi_arvalid & s_axi_arready;
   wire haveAw = awHave_q | awFire;
   wire haveW  = wHave_q | wFire;
   wire doWr   = haveAw & haveW;
   wire [ADDR_W-1:0] wAddr = awHave_q ? awAddr_q : s_axi_awaddr;
   wire [31:0] wDat  = wHave_q ? wData_q : s_axi_wdata;
   wire [31:0] wMsk  = laneMask(wHave_q ? wStrb_q : s_axi_wstrb);
   wire [31:0] wBits = wDat & wMsk;
   wire selThr  = wAddr == ADDR_THRESH;
   wire selClr  = wAddr == ADDR_IRQ_CLR;
   wire selEn   = wAddr == ADDR_IRQ_EN;
   wire wrMapped = selThr | selClr | selEn;
   wire [31:0] thrWord = {4'h0, thrLow_r, 4'h0, thrHigh_r};
   wire [31:0] thrNew  = (thrWord & ~wMsk) | wBits;
   wire [31:0] enNew   = (32'(irqEn_q) & ~wMsk) | wBits;

   assign irqClr = (doWr & selClr) ? wBits[IRQ_W-1:0] : '0;
   assign s_axi_awready = ~awHave_q & ~bvalid_q;
   assign s_axi_wready  = ~wHave_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdataR_q;

   wire [31:0] statusWord = {FILL_W'(rdFill_q), FILL_W'(wrFill_q), 1'b0,
                             outValid_q, thrLow_q, nearDrained_q,
                             ~outValid_q, thrHigh_q, nearCap_q, full_q};
   wire rdMapped = (s_axi_araddr == ADDR_THRESH)
                 | (s_axi_araddr == ADDR_STATUS)
                 | (s_axi_araddr == ADDR_IRQ_STAT)
                 | (s_axi_araddr == ADDR_IRQ_EN);
   wire [31:0] rdMux =
        (s_axi_araddr == ADDR_THRESH)   ? thrWord
      : (s_axi_araddr == ADDR_STATUS)   ? statusWord
      : (s_axi_araddr == ADDR_IRQ_STAT) ? 32'(irqStat_q)
      : (s_axi_araddr == ADDR_IRQ_EN)   ? 32'(irqEn_q)
      : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         awHave_q  <= 1'b0;
         wHave_q   <= 1'b0;
         awAddr_q  <= '0;
         wData_q   <= '0;
         wStrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         thrHigh_r <= THR_HIGH_RST;
         thrLow_r  <= THR_LOW_RST;
         irqEn_q   <= IRQ_EN_RST;
      end else begin
         if (s_axi_bready & bvalid_q) begin
            bvalid_q <= 1'b0;
         end
         if (doWr) begin
            awHave_q <= 1'b0;
            wHave_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            if (selThr) begin
               thrHigh_r <= thrNew[THR_HIGH_LSB +: 12];
               thrLow_r  <= thrNew[THR_LOW_LSB +: 12];
            end
            if (selEn) begin
               irqEn_q <= enNew[IRQ_W-1:0];
            end
         end else begin
            if (awFire) begin
               awHave_q <= 1'b1;
               awAddr_q <= s_axi_awaddr;
            end
            if (wFire) begin
               wHave_q <= 1'b1;
               wData_q <= s_axi_wdata;
               wStrb_q <= s_axi_wstrb;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdataR_q <= '0;
      end else if (arFire) begin
         rvalid_q <= 1'b1;
         rresp_q  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         rdataR_q <= rdMux;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // fflu_fifo_flags

// ### sim/fflu_fifo_flags_properties.sv
// Port-level timing assertions for the flag-timing FIFO
`timescale 1ns/1ps
module fflu_fifo_flags_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wrClkPin,
   input wire logic wrReqPin,
   input wire logic rdClkPin,
   input wire logic rdReqPin,
   input wire logic full,
   input wire logic nearCapacity,
   input wire logic wrAcceptPulse,
   input wire logic overflow,
   input wire logic empty,
   input wire logic rdValid,
   input wire logic underflow
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // =========================================================
   // Flag and handshake timing
   property p_empty_valid;
      empty == !rdValid;
   endproperty
   a_empty_valid: assert property (p_empty_valid)
      else $error("empty disagrees with valid");
   property p_full_near;
      full |-> nearCapacity;
   endproperty
   a_full_near: assert property (p_full_near)
      else $error("full without near capacity");
   property p_acc_tick;
      $changed(wrAcceptPulse) |-> $past(wrClkPin, 3) && !$past(wrClkPin, 4);
   endproperty
   a_acc_tick: assert property (p_acc_tick)
      else $error("accept moved off a write tick");
   property p_ovf_tick;
      $changed(overflow) |-> $past(wrClkPin, 3) && !$past(wrClkPin, 4);
   endproperty
   a_ovf_tick: assert property (p_ovf_tick)
      else $error("overflow moved off a write tick");
   property p_full_tick;
      $changed(full) |-> $past(wrClkPin, 3) && !$past(wrClkPin, 4);
   endproperty
   a_full_tick: assert property (p_full_tick)
      else $error("full moved off a write tick");
   property p_valid_tick;
      $changed(rdValid) |-> $past(rdClkPin, 3) && !$past(rdClkPin, 4);
   endproperty
   a_valid_tick: assert property (p_valid_tick)
      else $error("valid moved off a read tick");
   property p_und_tick;
      $changed(underflow) |-> $past(rdClkPin, 3) && !$past(rdClkPin, 4);
   endproperty
   a_und_tick: assert property (p_und_tick)
      else $error("underflow moved off a read tick");
   property p_acc_req;
      $rose(wrAcceptPulse) |-> $past(wrReqPin, 2) || $past(wrReqPin, 3);
   endproperty
   a_acc_req: assert property (p_acc_req)
      else $error("accept without a write request");
   property p_ovf_full;
      $rose(overflow) |-> full && !wrAcceptPulse;
   endproperty
   a_ovf_full: assert property (p_ovf_full)
      else $error("overflow while not full");
   property p_full_acc;
      $rose(full) |-> wrAcceptPulse;
   endproperty
   a_full_acc: assert property (p_full_acc)
      else $error("full rose without an accepted write");
   property p_und_req;
      $rose(underflow) |-> empty && ($past(rdReqPin, 2) || $past(rdReqPin, 3));
   endproperty
   a_und_req: assert property (p_und_req)
      else $error("underflow without a read of an empty fifo");
endmodule // fflu_fifo_flags_chk

bind fflu_fifo_flags fflu_fifo_flags_chk chk_i (.ref_clk, .reset_n,
   .wrClkPin, .wrReqPin, .rdClkPin, .rdReqPin, .full, .nearCapacity,
   .wrAcceptPulse, .overflow, .empty, .rdValid, .underflow);

// ### sim/fflu_user_model.sv
// Writer and reader logic driving the FIFO pins
`timescale 1ns/1ps
module fflu_user_model (
   output logic        wrClkPin,
   output logic        rdClkPin,
   output logic        wrReqPin,
   output logic [15:0] wrDataPin,
   output logic        rdReqPin
);
   // =========================================================
   // Free-running side clocks of unrelated phase
   initial begin
      wrClkPin  = 1'h0;
      rdClkPin  = 1'h0;
      wrReqPin  = 1'h0;
      wrDataPin = 16'h0000;
      rdReqPin  = 1'h0;
   end
   initial begin
      #23;
      forever #400 wrClkPin = ~wrClkPin;
   end
   initial begin
      #311;
      forever #400 rdClkPin = ~rdClkPin;
   end
   // =========================================================
   // Requests change on falling edges and hold a full period
   task automatic push(input logic [15:0] d, input int n);
      @(negedge wrClkPin);
      for (int i = 0; i < n; i++) begin
         wrReqPin  <= 1'h1;
         wrDataPin <= d + i[15:0];
         @(negedge wrClkPin);
      end
      wrReqPin  <= 1'h0;
      wrDataPin <= ~wrDataPin;
   endtask
   task automatic pop(input int n);
      @(negedge rdClkPin);
      rdReqPin <= 1'h1;
      repeat (n) @(negedge rdClkPin);
      rdReqPin <= 1'h0;
   endtask
endmodule // fflu_user_model

// ### sim/fflu_fifo_flags_tb.sv
// Self-checking bench for the flag-timing FIFO
`timescale 1ns/1ps
module fflu_fifo_flags_tb;
   import fflu_pkg::*;
   localparam int N = 2;
   logic        ref_clk, reset_n, irq;
   logic        wrClkPin, wrReqPin, rdClkPin, rdReqPin;
   logic [15:0] wrDataPin, rdData;
   logic        full, nearCapacity, thresholdHigh, wrAcceptPulse;
   logic        overflow, empty, nearDrained, thresholdLow;
   logic        rdValid, underflow;
   logic [11:0] wrFillLevel, rdFillLevel;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          failures = 0;
   int          checks = 0;
   int          cycles = 0;
   int          lag;

   fflu_fifo_flags #(.DEPTH(16)) fflu_fifo_flags_i (.*);
   fflu_user_model usr_i (.wrClkPin, .rdClkPin, .wrReqPin, .wrDataPin,
      .rdReqPin);

   // =========================================================
   // Clock, watchdog and shared tasks
   initial begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (failures == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                         input logic [1:0] r);
      logic       awGo, wGo, awPend, wPend, bSeen;
      logic [1:0] resp;
      awPend = 1'h1;
      wPend  = 1'h1;
      bSeen  = 1'h0;
      @(posedge ref_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      while (!bSeen) begin
         @(negedge ref_clk);
         awGo  = awPend & s_axi_awready;
         wGo   = wPend & s_axi_wready;
         bSeen = s_axi_bvalid;
         resp  = s_axi_bresp;
         @(posedge ref_clk);
         if (awGo) s_axi_awvalid <= 1'h0;
         if (wGo) s_axi_wvalid <= 1'h0;
         awPend = awPend & ~awGo;
         wPend  = wPend & ~wGo;
      end
      s_axi_bready <= 1'h0;
      chk("bresp", r, resp);
   endtask
   task automatic axi_rd(input logic [4:0] a, input logic [31:0] e,
                         input logic [31:0] m, input logic [1:0] r);
      logic        arGo, arPend, rSeen;
      logic [31:0] data;
      logic [1:0]  resp;
      arPend = 1'h1;
      rSeen  = 1'h0;
      @(posedge ref_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      while (!rSeen) begin
         @(negedge ref_clk);
         arGo  = arPend & s_axi_arready;
         rSeen = s_axi_rvalid;
         data  = s_axi_rdata;
         resp  = s_axi_rresp;
         @(posedge ref_clk);
         if (arGo) s_axi_arvalid <= 1'h0;
         arPend = arPend & ~arGo;
      end
      s_axi_rready <= 1'h0;
      chk("rdata", e, data & m);
      chk("rresp", r, resp);
   endtask

   // =========================================================
   // Test sequence
   initial begin
      reset_n       = 1'h0;
      s_axi_awaddr  = 5'h00;
      s_axi_araddr  = 5'h00;
      s_axi_wdata   = 32'h0;
      s_axi_wstrb   = 4'hF;
      s_axi_awvalid = 1'h0;
      s_axi_wvalid  = 1'h0;
      s_axi_bready  = 1'h0;
      s_axi_arvalid = 1'h0;
      s_axi_rready  = 1'h0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge ref_clk);
      chk("empty", 1, empty);
      chk("full", 0, full);
      axi_rd(ADDR_THRESH, {4'h0, THR_LOW_RST, 4'h0, THR_HIGH_RST},
             32'hFFFFFFFF, RESP_OKAY);
      axi_rd(ADDR_IRQ_EN, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
      axi_rd(ADDR_IRQ_CLR, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      axi_rd(5'h14, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      axi_wr(5'h14, 32'hFFFFFFFF, RESP_SLVERR);
      axi_wr(ADDR_THRESH, 32'h00020004, RESP_OKAY);
      axi_rd(ADDR_THRESH, 32'h00020004, 32'hFFFFFFFF, RESP_OKAY);
      usr_i.pop(1);
      chk("underflow", 1, underflow);
      chk("overflow", 0, overflow);
      @(negedge rdClkPin);
      chk("underflow", 0, underflow);
      usr_i.push(16'hA5C3, 1);
      chk("wrAcceptPulse", 1, wrAcceptPulse);
      chk("underflow", 0, underflow);
      @(negedge wrClkPin);
      chk("wrFillLevel", 1, wrFillLevel);
      lag = 0;
      while (empty && lag < 12) begin
         @(negedge rdClkPin);
         lag++;
      end
      chk("empty lag", 1, lag >= N + 3 && lag <= N + 6);
      chk("rdData", 16'hA5C3, rdData);
      chk("nearDrained", 1, nearDrained);
      chk("rdFillLevel", 1, rdFillLevel);
      usr_i.pop(1);
      chk("rdValid", 0, rdValid);
      chk("underflow", 0, underflow);
      @(negedge rdClkPin);
      chk("rdFillLevel", 0, rdFillLevel);
      usr_i.push(16'h0100, 4);
      chk("thresholdHigh", 0, thresholdHigh);
      @(negedge wrClkPin);
      chk("thresholdHigh", 1, thresholdHigh);
      usr_i.push(16'h0104, 12);
      chk("nearCapacity", 1, nearCapacity);
      chk("full", 0, full);
      usr_i.push(16'h0110, 1);
      chk("full", 1, full);
      usr_i.push(16'hDEAD, 1);
      chk("overflow", 1, overflow);
      chk("wrAcceptPulse", 0, wrAcceptPulse);
      @(negedge wrClkPin);
      axi_rd(ADDR_IRQ_STAT, 32'h5, 32'h5, RESP_OKAY);
      chk("irq", 0, irq);
      axi_wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
      @(negedge ref_clk);
      chk("irq", 1, irq);
      axi_wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
      @(negedge ref_clk);
      chk("irq", 0, irq);
      chk("rdData", 16'h0100, rdData);
      usr_i.pop(1);
      chk("rdData", 16'h0101, rdData);
      lag = 0;
      while (full && lag < 12) begin
         @(negedge wrClkPin);
         lag++;
      end
      chk("full lag", 1, lag >= N + 1 && lag <= N + 4);
      chk("nearCapacity", 1, nearCapacity);
      chk("overflow", 0, overflow);
      chk("thresholdLow", 0, thresholdLow);
      complete_run();
   end
endmodule // fflu_fifo_flags_tb
